// >>> thermal_pin_config_and_timer.sv
`timescale 1ns/10ps
`default_nettype none

module thermal_pin_config_and_timer
    import thermal_cfg_pkg::*;
#(
    parameter int unsigned STEP_CYCLES      = TIMER_STEP_CYCLES,
    parameter int unsigned TACH_FAST_PERIOD = TACH_FAST_CYCLES,
    parameter int unsigned TACH_NORM_PERIOD = TACH_NORM_CYCLES
)(
    // clock, reset, clock enable
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // axi4-lite write address
    input  wire logic [11:0] i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    // axi4-lite write data
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    // axi4-lite write response
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    // axi4-lite read address
    input  wire logic [11:0] i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    // axi4-lite read data
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // shared pin 10: fan drive two or active-low alert
    input  wire logic        i_fan_drive_two_pwm,
    output logic             o_pin10_out,
    output logic             o_pin10_oe,
    // shared pin 22: 2.5 v measurement or thermal pin
    input  wire logic        i_pin22_in,
    output logic             o_pin22_out,
    output logic             o_pin22_oe,
    output logic             o_meas_2v5_pin22,
    // shared pin 14: thermal pin when selected
    input  wire logic        i_pin14_in,
    output logic             o_pin14_out,
    output logic             o_pin14_oe,
    // overtemperature request from the monitor, drives thermal pin low when two-way
    input  wire logic        i_overtemp_req,
    // fan and tach control
    output logic             o_fan_max_duty,
    output logic             o_tach_measure_start,
    output logic [3:0]       o_tach_continuous,
    output logic [3:0]       o_pulse_stretch_en,
    // interrupt
    output logic             o_irq
);

    typedef struct packed {
        // axi write side
        logic        awrdy;        // ready for a write address
        logic        wrdy;         // ready for write data
        logic [11:0] awaddr;       // held write address
        logic [7:0]  wdata;        // held write data, low lane
        logic        wlane;        // low byte lane strobed
        logic        bvalid;       // write response pending
        logic [1:0]  bresp;        // write response code
        // axi read side
        logic        arrdy;        // ready for a read address
        logic        rvalid;       // read data pending
        logic [7:0]  rdata;        // read data, low lane
        logic [1:0]  rresp;        // read response code
        // registers
        logic [7:0]  pin_cfg;      // pin function and tach config
        logic [7:0]  dir_cfg;      // direction config
        logic [7:0]  limit;        // assertion_time_limit
        logic        lock;         // lock for pin_cfg writes only, set only
        logic [1:0]  pin_b_sel;    // shared_pin_b_function_select
        logic [1:0]  irq_stat;     // sticky event bits
        logic [1:0]  irq_mask;     // 1 masks the event
        // assertion timer
        logic        prev_assert;  // thermal input asserted last cycle
        logic        flag_lsb;     // assertion_flag_lsb
        logic [7:0]  dur;          // assertion_duration_count
        // registered pin and control outputs
        logic        pin10_out;
        logic        pin10_oe;
        logic        pin22_oe;
        logic        pin14_oe;
        logic        meas_2v5;
        logic        fan_max;
        logic [3:0]  tach_cont;
        logic [3:0]  stretch_en;
        logic        irq;
    } state_s;

    state_s q, d;

    logic        step_tick;     // one step of the assertion timer elapsed
    logic        tach_tick;     // start of a tach measurement round
    logic        asserted;      // selected thermal pin is low
    logic [31:0] tach_period;   // chosen tach measurement period

    // thermal pin routing from the enable bit and pin b select
    logic thermal_limit_pin_on_14;
    logic thermal_limit_pin_on_22;
    logic two_way;

    assign thermal_limit_pin_on_14 = (q.pin_b_sel == PIN_B_THERMAL);
    assign thermal_limit_pin_on_22 = q.pin_cfg[BIT_THERMAL_LIMIT_PIN_EN] && !thermal_limit_pin_on_14;
    assign two_way     = &q.dir_cfg[7:BIT_DIR_LO];
    assign asserted    = thermal_limit_pin_on_14 ? !i_pin14_in : (thermal_limit_pin_on_22 && !i_pin22_in);

    // tach period follows the fast bit
    assign tach_period = q.pin_cfg[BIT_FAST] ? TACH_FAST_PERIOD
                                             : TACH_NORM_PERIOD;

    // step timer runs only while the input stays asserted
    period_tick u_step (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_restart (!asserted),
        .i_period  (STEP_CYCLES),
        .o_tick    (step_tick)
    );

    // tach round timer for all channels
    period_tick u_tach (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_restart (1'b0),
        .i_period  (tach_period),
        .o_tick    (tach_tick)
    );

    // next state of the whole block
    always_comb begin
        logic       rise;
        logic       read_tmr;
        logic       do_write;
        logic       limit_hit;
        logic [1:0] clr;
        logic [7:0] dur_n;
        logic [7:0] ridx;
        logic [7:0] widx;
        logic       irq_n;
        rise      = 1'b0;
        read_tmr  = 1'b0;
        do_write  = 1'b0;
        limit_hit = 1'b0;
        clr       = 2'h0;
        dur_n     = q.dur;
        ridx      = i_araddr[9:2];
        widx      = q.awaddr[9:2];
        irq_n     = 1'b0;
        d = q;

        // write address and data captured in either order
        if (q.awrdy && i_awvalid) begin
            d.awaddr = i_awaddr;
            d.awrdy  = 1'b0;
        end
        if (q.wrdy && i_wvalid) begin
            d.wdata = i_wdata[7:0];
            d.wlane = i_wstrb[0];
            d.wrdy  = 1'b0;
        end

        // both halves held: perform the write and answer
        if (!q.awrdy && !q.wrdy && !q.bvalid) begin
            do_write = 1'b1;
            d.bvalid = 1'b1;
            d.bresp  = RESP_OKAY;
            if (q.awaddr[11:10] != 2'h0) begin
                d.bresp = RESP_SLVERR;
            end else if (q.wlane) begin
                unique case (widx)
                    IDX_PIN_CFG:    if (!q.lock) d.pin_cfg = q.wdata;
                    IDX_TMR_STATUS: d.bresp = RESP_OKAY;                 // read-only, ignored
                    IDX_TMR_LIMIT:  d.limit     = q.wdata;
                    IDX_DIR_CFG:    d.dir_cfg   = q.wdata;
                    IDX_LOCK:       d.lock      = q.lock | q.wdata[0];
                    IDX_PIN_B_SEL:  d.pin_b_sel = q.wdata[1:0];
                    IDX_IRQ_STATUS: clr         = q.wdata[1:0];
                    IDX_IRQ_MASK:   d.irq_mask  = q.wdata[1:0];
                    default:        d.bresp     = RESP_SLVERR;
                endcase
            end else if (!(widx inside {IDX_PIN_CFG, IDX_TMR_STATUS, IDX_TMR_LIMIT,
                                        IDX_DIR_CFG, IDX_LOCK, IDX_PIN_B_SEL,
                                        IDX_IRQ_STATUS, IDX_IRQ_MASK})) begin
                d.bresp = RESP_SLVERR;
            end
        end

        // write response taken: reopen both channels
        if (q.bvalid && i_bready) begin
            d.bvalid = 1'b0;
            d.awrdy  = 1'b1;
            d.wrdy   = 1'b1;
        end

        // read: one cycle from address to data
        if (q.arrdy && i_arvalid) begin
            d.arrdy  = 1'b0;
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = 8'h00;
            if (i_araddr[11:10] != 2'h0) begin
                d.rresp = RESP_SLVERR;
            end else begin
                unique case (ridx)
                    IDX_PIN_CFG:    d.rdata = q.pin_cfg;
                    IDX_TMR_STATUS: begin
                        d.rdata  = {7'h00, q.flag_lsb};
                        if (q.dur >= REPORT_MIN_STEPS) d.rdata = q.dur;
                        read_tmr = 1'b1;
                    end
                    IDX_TMR_LIMIT:  d.rdata = q.limit;
                    IDX_DIR_CFG:    d.rdata = q.dir_cfg;
                    IDX_LOCK:       d.rdata = {7'h00, q.lock};
                    IDX_PIN_B_SEL:  d.rdata = {6'h00, q.pin_b_sel};
                    IDX_IRQ_STATUS: d.rdata = {6'h00, q.irq_stat};
                    IDX_IRQ_MASK:   d.rdata = {6'h00, q.irq_mask};
                    default:        d.rresp = RESP_SLVERR;
                endcase
            end
        end
        if (q.rvalid && i_rready) begin
            d.rvalid = 1'b0;
            d.arrdy  = 1'b1;
        end

        // assertion timer
        rise          = asserted && !q.prev_assert;
        d.prev_assert = asserted;
        if (rise) begin
            dur_n = 8'h00;
        end else if (step_tick && asserted && q.dur != DURATION_MAX) begin
            dur_n     = q.dur + 8'h01;
            // a zero limit fires only on the rising edge, never per step
            limit_hit = (dur_n > q.limit) && (q.limit != 8'h00);
        end
        d.dur = dur_n;
        if (rise && q.limit == 8'h00) begin
            limit_hit = 1'b1;
        end

        // flag: read clears, a new assertion in the same cycle wins
        d.flag_lsb = rise || (q.flag_lsb && !read_tmr);

        // sticky events: write one clears, set wins
        d.irq_stat = q.irq_stat & ~clr;
        d.irq_stat[IRQ_LIMIT]  = d.irq_stat[IRQ_LIMIT] | limit_hit;
        d.irq_stat[IRQ_ASSERT] = d.irq_stat[IRQ_ASSERT] | rise;
        irq_n = |(d.irq_stat & ~d.irq_mask);
        d.irq = irq_n;

        // pin 10: open-drain alert low while irq, or fan drive two
        d.pin10_out = !d.pin_cfg[BIT_ALERT_SEL] && i_fan_drive_two_pwm;
        d.pin10_oe  = !d.pin_cfg[BIT_ALERT_SEL] || irq_n;

        // thermal pin pulled low only when two-way and overtemperature
        d.pin22_oe = thermal_limit_pin_on_22 && two_way && i_overtemp_req;
        d.pin14_oe = thermal_limit_pin_on_14 && two_way && i_overtemp_req;
        d.meas_2v5 = !thermal_limit_pin_on_22;

        // boost while the thermal input is asserted from outside
        d.fan_max = q.pin_cfg[BIT_BOOST] && asserted
                    && !(two_way && i_overtemp_req);

        // dc modes: continuous tach, no pulse stretching
        d.tach_cont  = q.pin_cfg[7:BIT_DC_LO];
        d.stretch_en = ~q.pin_cfg[7:BIT_DC_LO];
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            q            <= '0;
            q.awrdy      <= 1'b1;
            q.wrdy       <= 1'b1;
            q.arrdy      <= 1'b1;
            q.pin_cfg    <= RST_PIN_CFG;
            q.dir_cfg    <= RST_DIR_CFG;
            q.limit      <= RST_TMR_LIMIT;
            q.pin_b_sel  <= RST_PIN_B_SEL;
            q.pin10_oe   <= 1'b1;
            q.meas_2v5   <= 1'b1;
            q.stretch_en <= 4'hf;
        end else if (i_ce) begin
            q <= d;
        end
    end

    // output drive, all from flip-flops or tied low
    assign o_awready         = q.awrdy;
    assign o_wready          = q.wrdy;
    assign o_bvalid          = q.bvalid;
    assign o_bresp           = q.bresp;
    assign o_arready         = q.arrdy;
    assign o_rvalid          = q.rvalid;
    assign o_rresp           = q.rresp;
    assign o_rdata           = {24'h000000, q.rdata};
    assign o_pin10_out       = q.pin10_out;
    assign o_pin10_oe        = q.pin10_oe;
    assign o_pin22_out       = 1'b0;
    assign o_pin22_oe        = q.pin22_oe;
    assign o_pin14_out       = 1'b0;
    assign o_pin14_oe        = q.pin14_oe;
    assign o_meas_2v5_pin22  = q.meas_2v5;
    assign o_fan_max_duty    = q.fan_max;
    assign o_tach_measure_start = tach_tick;
    assign o_tach_continuous = q.tach_cont;
    assign o_pulse_stretch_en = q.stretch_en;
    assign o_irq             = q.irq;

endmodule // thermal_pin_config_and_timer

`default_nettype wire

// >>> thermal_cfg_pkg.sv
// shared constants for the thermal pin configuration and assertion timer
package thermal_cfg_pkg;

    // clock rate, used to turn times into cycle counts
    localparam int unsigned CLK_MHZ            = 100;

    // assertion timer step: 22.76 ms, in microseconds
    localparam int unsigned TIMER_STEP_US      = 22760;
    localparam int unsigned TIMER_STEP_CYCLES  = TIMER_STEP_US * CLK_MHZ;
    // upper bits stay zero until the assertion exceeds 45.52 ms (two steps)
    localparam logic [7:0]  REPORT_MIN_STEPS   = 8'h02;
    // duration count saturation value
    localparam logic [7:0]  DURATION_MAX       = 8'hff;

    // tach measurement period in fast mode: 250 ms, in microseconds
    localparam int unsigned TACH_FAST_US       = 250000;
    localparam int unsigned TACH_FAST_CYCLES   = TACH_FAST_US * CLK_MHZ;
    // normal rate is a quarter of the fast rate
    localparam int unsigned TACH_RATE_FACTOR   = 4;
    localparam int unsigned TACH_NORM_CYCLES   = TACH_FAST_CYCLES * TACH_RATE_FACTOR;

    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_PIN_CFG        = 8'h78;
    localparam logic [7:0]  IDX_TMR_STATUS     = 8'h79;
    localparam logic [7:0]  IDX_TMR_LIMIT      = 8'h7a;
    localparam logic [7:0]  IDX_DIR_CFG        = 8'h7c;
    localparam logic [7:0]  IDX_LOCK           = 8'h80;
    localparam logic [7:0]  IDX_PIN_B_SEL      = 8'h81;
    localparam logic [7:0]  IDX_IRQ_STATUS     = 8'h82;
    localparam logic [7:0]  IDX_IRQ_MASK       = 8'h83;

    // reset values
    localparam logic [7:0]  RST_PIN_CFG        = 8'h00;
    localparam logic [7:0]  RST_TMR_LIMIT      = 8'h00;
    localparam logic [7:0]  RST_DIR_CFG        = 8'h01;
    localparam logic [1:0]  RST_PIN_B_SEL      = 2'h0;

    // pin function config bit positions
    localparam int unsigned BIT_ALERT_SEL      = 0;
    localparam int unsigned BIT_THERMAL_LIMIT_PIN_EN       = 1;
    localparam int unsigned BIT_BOOST          = 2;
    localparam int unsigned BIT_FAST           = 3;
    localparam int unsigned BIT_DC_LO          = 4;
    // direction config: bits [7:5] all set make the thermal pin two-way
    localparam int unsigned BIT_DIR_LO         = 5;
    // shared pin b select code that puts the thermal function on pin 14
    localparam logic [1:0]  PIN_B_THERMAL      = 2'h1;

    // interrupt status / mask bit positions
    localparam int unsigned IRQ_LIMIT          = 0;
    localparam int unsigned IRQ_ASSERT         = 1;

    // axi responses
    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

endpackage

// >>> period_tick.sv
`timescale 1ns/10ps
`default_nettype none

// free counter that pulses once every i_period cycles, restartable
module period_tick
    import thermal_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // control
    input  wire logic        i_restart,
    input  wire logic [31:0] i_period,
    // tick out
    output logic             o_tick
);

    typedef struct packed {
        logic [31:0] cnt;   // cycles since last tick
        logic        tick;  // one-cycle pulse
    } tick_s;

    tick_s q, d;

    // next state: hold at zero on restart, else wrap at period
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (i_restart) begin
            d.cnt = 32'h0;
        end else if (q.cnt >= i_period - 32'h1) begin
            d.cnt  = 32'h0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 32'h1;
        end
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_tick = q.tick;

endmodule // period_tick

`default_nettype wire

// >>> thermal_chk.sv
`timescale 1ns/10ps
`default_nettype none
// watches bus answers, shared pins and tach outputs of the thermal block
module thermal_chk (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // register bus
    input  wire logic        i_arvalid,
    input  wire logic        o_arready,
    input  wire logic        o_rvalid,
    input  wire logic        i_rready,
    input  wire logic [31:0] o_rdata,
    input  wire logic        o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [1:0]  o_bresp,
    // shared pins
    input  wire logic        i_fan_drive_two_pwm,
    input  wire logic        o_pin10_out,
    input  wire logic        o_pin10_oe,
    input  wire logic        o_pin22_oe,
    input  wire logic        o_meas_2v5_pin22,
    input  wire logic        i_overtemp_req,
    // tach control
    input  wire logic        o_tach_measure_start,
    input  wire logic [3:0]  o_tach_continuous,
    input  wire logic [3:0]  o_pulse_stretch_en
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_stretch; o_pulse_stretch_en == ~o_tach_continuous; endproperty
    a_stretch: assert property (p_stretch) else $error("stretch not inverse of dc mode");
    property p_pin10; o_pin10_out |-> o_pin10_oe && $past(i_fan_drive_two_pwm); endproperty
    a_pin10: assert property (p_pin10) else $error("pin10 high without pwm");
    property p_oe_meas; o_pin22_oe |-> !o_meas_2v5_pin22; endproperty
    a_oe_meas: assert property (p_oe_meas) else $error("pin22 driven while measuring");
    property p_oe_req; o_pin22_oe |-> $past(i_overtemp_req); endproperty
    a_oe_req: assert property (p_oe_req) else $error("pin22 driven without request");
    property p_tach; o_tach_measure_start |=> !o_tach_measure_start; endproperty
    a_tach: assert property (p_tach) else $error("tach start longer than one cycle");
    property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rlat; i_arvalid && o_arready |=> o_rvalid && o_rdata[31:8] == 24'h0; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late or wide");
endmodule // thermal_chk
bind thermal_pin_config_and_timer thermal_chk thermal_chk_inst (
    .i_mclk, .i_rst, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_rdata, .o_bvalid,
    .i_bready, .o_bresp, .i_fan_drive_two_pwm, .o_pin10_out, .o_pin10_oe, .o_pin22_oe,
    .o_meas_2v5_pin22, .i_overtemp_req, .o_tach_measure_start, .o_tach_continuous,
    .o_pulse_stretch_en
);
`default_nettype wire

// >>> thermal_far_side_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side: pulled-up thermal wires, a thermal source and the fan loop pwm
module thermal_far_side_model (
    // clock and bench command
    input  wire logic i_mclk,
    input  wire logic i_hold_pin22,
    // device drive enables
    input  wire logic i_pin22_oe,
    input  wire logic i_pin14_oe,
    // wire levels and pwm
    output logic      o_pin22,
    output logic      o_pin14,
    output logic      o_pwm
);
    logic [2:0] pwm_cnt_q = 3'h0; // slow square wave source
    // wires are pulled up and read low when any party pulls them
    assign o_pin22 = ~(i_hold_pin22 | i_pin22_oe);
    assign o_pin14 = ~i_pin14_oe;
    assign o_pwm   = pwm_cnt_q[2];
    always @(posedge i_mclk) begin
        pwm_cnt_q <= pwm_cnt_q + 3'h1;
    end
endmodule // thermal_far_side_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// register, pin and timer scenarios for the thermal block
module tb_top import thermal_cfg_pkg::*;;
    logic        i_mclk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_overtemp_req = 1'b0;
    logic [11:0] i_awaddr = 12'h0, i_araddr = 12'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [3:0]  i_wstrb = 4'hf, o_tach_continuous, o_pulse_stretch_en;
    logic [1:0]  o_bresp, o_rresp;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0, hold22 = 1'b0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic        i_fan_drive_two_pwm, o_pin10_out, o_pin10_oe, i_pin22_in, o_pin22_out;
    logic        o_pin22_oe, o_meas_2v5_pin22, i_pin14_in, o_pin14_out, o_pin14_oe;
    logic        o_fan_max_duty, o_tach_measure_start;
    int          err_total = 0, n_checks = 0;
    always #5 i_mclk = ~i_mclk;
    // short timer step and tach periods keep the run brief
    thermal_pin_config_and_timer #(.STEP_CYCLES(20), .TACH_FAST_PERIOD(16),
        .TACH_NORM_PERIOD(64)) thermal_pin_config_and_timer_inst (
        .i_mclk, .i_rst, .i_ce, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_fan_drive_two_pwm,
        .o_pin10_out, .o_pin10_oe, .i_pin22_in, .o_pin22_out, .o_pin22_oe,
        .o_meas_2v5_pin22, .i_pin14_in, .o_pin14_out, .o_pin14_oe, .i_overtemp_req,
        .o_fan_max_duty, .o_tach_measure_start, .o_tach_continuous,
        .o_pulse_stretch_en, .o_irq);
    thermal_far_side_model thermal_far_side_model_inst (.i_mclk, .i_hold_pin22(hold22),
        .i_pin22_oe(o_pin22_oe), .i_pin14_oe(o_pin14_oe), .o_pin22(i_pin22_in),
        .o_pin14(i_pin14_in), .o_pwm(i_fan_drive_two_pwm));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // wait n edges, then settle to the falling edge for sampling
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    // one register access: requests held until taken, answer judged at its edge
    task automatic bus(input bit w, input logic [7:0] ix, input logic [7:0] d,
                       input logic [1:0] er);
        logic ta, tw, fin, rdy;
        @(posedge i_mclk);
        i_awaddr <= {2'h0, ix, 2'h0};
        i_araddr <= {2'h0, ix, 2'h0};
        i_wdata <= {24'h0, d};
        i_awvalid <= w;
        i_wvalid <= w;
        i_arvalid <= !w;
        repeat (40) begin
            @(negedge i_mclk);
            ta = (i_awvalid && o_awready) || (i_arvalid && o_arready);
            tw = i_wvalid && o_wready;
            fin = w ? o_bvalid : o_rvalid;
            // answer ready rises only once the answer is seen, so answers wait a cycle
            rdy = fin && (i_bready || i_rready);
            if (rdy) begin
                chk($sformatf("resp %h", ix), er, w ? o_bresp : o_rresp);
                if (!w) chk($sformatf("data %h", ix), d, o_rdata);
            end
            @(posedge i_mclk);
            if (ta) begin
                i_awvalid <= 1'b0;
                i_arvalid <= 1'b0;
            end
            if (tw) i_wvalid <= 1'b0;
            if (rdy) begin
                i_bready <= 1'b0;
                i_rready <= 1'b0;
                return;
            end
            if (fin) begin
                i_bready <= w;
                i_rready <= !w;
            end
        end
        err_total++;
        print_verdict();
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        bus(1'b1, ix, d, RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] ix, input logic [7:0] e);
        bus(1'b0, ix, e, RESP_OKAY);
    endtask
    // reset values, refused index, dc modes and pin select table
    task automatic t_cfg;
        rd(IDX_PIN_CFG, RST_PIN_CFG);
        rd(IDX_TMR_STATUS, 8'h00);
        rd(IDX_DIR_CFG, RST_DIR_CFG);
        bus(1'b0, 8'h90, 8'h00, RESP_SLVERR);
        bus(1'b1, 8'h90, 8'h5a, RESP_SLVERR);
        chk("pin10 oe", 1, o_pin10_oe);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_PIN_CFG, 8'h10 << i);
            tick(2);
            chk("continuous", 4'h1 << i, o_tach_continuous);
            chk("stretch", {28'h0, ~(4'h1 << i)}, o_pulse_stretch_en);
        end
        for (int s = 0; s < 4; s++) begin
            wr(IDX_PIN_B_SEL, 8'(s));
            wr(IDX_PIN_CFG, 8'h02);
            tick(2);
            chk("meas 2v5", s == 1, o_meas_2v5_pin22);
        end
        wr(IDX_PIN_B_SEL, 8'h00);
        $display("config test done");
    endtask
    // tach starts counted over a window of whole periods
    task automatic t_tach;
        int n;
        for (int f = 0; f < 2; f++) begin
            wr(IDX_PIN_CFG, f ? 8'h08 : 8'h00);
            tick(8);
            n = 0;
            repeat (256) begin
                @(negedge i_mclk);
                n += o_tach_measure_start;
            end
            chk("tach starts", f ? 16 : 4, n);
        end
        $display("tach test done");
    endtask
    // one long assertion on pin 22, alert mode, limit 3
    task automatic t_timer;
        wr(IDX_TMR_LIMIT, 8'h03);
        wr(IDX_PIN_CFG, 8'h03);
        @(posedge i_mclk);
        hold22 <= 1'b1;
        tick(3);
        rd(IDX_TMR_STATUS, 8'h01);
        rd(IDX_TMR_STATUS, 8'h00);
        tick(15);
        rd(IDX_TMR_STATUS, 8'h00);
        rd(IDX_IRQ_STATUS, 8'h02);
        tick(13);
        rd(IDX_TMR_STATUS, 8'h02);
        tick(35);
        rd(IDX_IRQ_STATUS, 8'h03);
        chk("irq", 1, o_irq);
        chk("alert low", 0, o_pin10_out);
        chk("alert drive", 1, o_pin10_oe);
        wr(IDX_IRQ_MASK, 8'h03);
        tick(2);
        chk("irq masked", 0, o_irq);
        wr(IDX_IRQ_MASK, 8'h00);
        tick(5300);
        rd(IDX_TMR_STATUS, 8'hff);
        @(posedge i_mclk);
        hold22 <= 1'b0;
        wr(IDX_IRQ_STATUS, 8'h03);
        tick(2);
        chk("irq cleared", 0, o_irq);
        chk("alert off", 0, o_pin10_oe);
        $display("timer test done");
    endtask
    // boost, zero limit, two-way drive and lock
    task automatic t_misc;
        wr(IDX_TMR_LIMIT, 8'h00);
        wr(IDX_PIN_CFG, 8'h06);
        @(posedge i_mclk);
        hold22 <= 1'b1;
        tick(4);
        chk("boost", 1, o_fan_max_duty);
        rd(IDX_IRQ_STATUS, 8'h03);
        @(posedge i_mclk);
        hold22 <= 1'b0;
        wr(IDX_DIR_CFG, 8'he1);
        @(posedge i_mclk);
        i_overtemp_req <= 1'b1;
        tick(3);
        chk("two-way", 1, o_pin22_oe);
        wr(IDX_DIR_CFG, 8'h01);
        tick(2);
        chk("input only", 0, o_pin22_oe);
        wr(IDX_PIN_B_SEL, 8'h01);
        wr(IDX_DIR_CFG, 8'he1);
        tick(2);
        chk("two-way 14", 1, o_pin14_oe);
        chk("pin22 released", 0, o_pin22_oe);
        wr(IDX_LOCK, 8'h01);
        wr(IDX_PIN_CFG, 8'hf0);
        rd(IDX_PIN_CFG, 8'h06);
        $display("misc test done");
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_cfg();
        t_tach();
        t_timer();
        t_misc();
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
